/* rtl/smv_sync.v */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// three-stage input filter
// ----------------------------------------
module smv_sync #(
  parameter WIDTH = 2
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer         k;

  always @(posedge clk) begin
    if (rst) begin
      stage1 <= {WIDTH{1'b1}};
      stage2 <= {WIDTH{1'b1}};
      stage3 <= {WIDTH{1'b1}};
      dout   <= {WIDTH{1'b1}};
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      // level counts only once stages two and three agree
      for (k = 0; k < WIDTH; k = k + 1) begin
        if (stage2[k] == stage3[k])
          dout[k] <= stage3[k];
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/smv_verify_top.v */
// Summary of operation
// (R1) key index, 8 random, 8 challenge, then compute
// (R2) challenge from random, cryptogram, seed or key
// (R3) decrement auth counter before comparing
// (R4) on match write new cryptogram and key
// (R5) success sets auth counter to all ones
// (R6) key index: nibble 0 seed, 1 session
// (R7) host polls with B2 or B6 afterwards
// (R8) host checks counter or cryptogram for outcome
// (R9) password index 00-07 write, 10-17 read
// (R10) index bit4 selects read, three-bit set
// (R11) config locked until write password seven
// (R12) host polls with B6 after password
// (R13) correct password sets counter to all ones
// (R14) unlocked config read shows code at E9
// (R15) default user zones grant full access
// (R16) config writes take effect at once
// (R17) host blows fuses in strict order
// (R18) all fuses blown reads zero nibble
// (R19) host writes user data before security
// (R20) out-of-order fuse writes rejected
// (R21) fuse state bits 0-3, zero blown
// (R22) no byte acknowledge while processing
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "smv_consts.vh"

module smv_verify_top #(
  parameter NV_WAIT = `SMV_T_NVWRITE_NS / `SMV_CLK_PERIOD_NS
) (
  // system
  input  wire        CLK_SYS,
  input  wire        RESET,
  // wishbone slave
  input  wire        WB_CYC,
  input  wire        WB_STB,
  input  wire        WB_WE,
  input  wire [7:0]  WB_ADR,
  input  wire [3:0]  WB_SEL,
  input  wire [31:0] WB_DAT_W,
  output reg  [31:0] WB_DAT_R,
  output reg         WB_ACK,
  // two-wire link
  input  wire        SCL,
  input  wire        SDA_I,
  output reg         SDA_O,
  output reg         SDA_OE
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // stand-in mixing step for the cipher
  function [7:0] mix;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    input [3:0] i;
    begin
      mix = {a[6:0], a[7]} ^ b ^ (c + {4'h0, i});
    end
  endfunction

  function [7:0] dec8;
    input [7:0] v;
    begin
      dec8 = (v == 8'h00) ? 8'h00 : v - 8'h01;
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam [7:0] P_IDLE = 8'h01;
  localparam [7:0] P_DEC  = 8'h02;
  localparam [7:0] P_CALC = 8'h04;
  localparam [7:0] P_UPD  = 8'h08;
  localparam [7:0] P_FIN  = 8'h10;
  localparam [7:0] P_PW   = 8'h20;
  localparam [7:0] P_FUSE = 8'h40;
  localparam [7:0] P_WAIT = 8'h80;
  localparam [15:0] NV_CYCLES = NV_WAIT[15:0];

  reg  [7:0]  mem [0:255];
  reg  [7:0]  buf_data [0:15];
  reg  [7:0]  pstate;
  reg  [3:0]  step;
  reg  [15:0] wait_cnt;
  reg         mismatch;
  reg         last_ok;
  reg         unlocked;
  reg  [3:0]  fuse;
  reg         go;
  reg  [7:0]  cfg_index;
  reg  [7:0]  cmd;
  reg  [7:0]  p1;
  reg  [7:0]  p2;
  reg  [7:0]  nbyte;
  reg  [7:0]  shift;
  reg  [7:0]  tx_addr;
  reg  [4:0]  byte_idx;
  reg  [3:0]  bit_cnt;
  reg         active;
  reg         tx_mode;
  reg         nack_seen;
  reg         skip_fall;
  reg         scl_q;
  reg         sda_q;
  wire [1:0]  pins_s;
  wire        scl_s = pins_s[1];
  wire        sda_s = pins_s[0];
  integer     n;
  integer     m;

  smv_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .din  ({SCL, SDA_I}),
    .dout (pins_s)
  );

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire [1:0] kset       = p1[1:0];
  wire [7:0] ctr_addr   = `SMV_AUTH_BASE + {2'b00, kset, 4'h0};
  wire [7:0] c_addr     = ctr_addr + 8'h01 + {5'h00, step[2:0]};
  wire [7:0] s_addr     = `SMV_S_BASE + {3'b000, kset, step[2:0]};
  wire [7:0] g_addr     = `SMV_G_BASE + {3'b000, kset, step[2:0]};
  wire [7:0] k_addr     = p1[4] ? s_addr : g_addr;
  wire [7:0] pw_ctr     = `SMV_PW_BASE + {2'b00, p1[2:0], p1[4], 2'b00};
  wire       busy       = (pstate != P_IDLE) | go;
  wire [7:0] expect_ch  = mix(buf_data[{1'b0, step[2:0]}], mem[c_addr],
                              mem[k_addr], step);
  wire       pw_match   = (mem[pw_ctr + 8'h01] == buf_data[0]) &
                          (mem[pw_ctr + 8'h02] == buf_data[1]) &
                          (mem[pw_ctr + 8'h03] == buf_data[2]);
  wire       wb_req     = WB_CYC & WB_STB & ~WB_ACK;
  wire       wb_mem_we  = wb_req & WB_WE & WB_SEL[0] & unlocked & ~busy &
                          (WB_ADR == `SMV_REG_CFG_DATA);

  // ----------------------------------------
  // processing write port
  // ----------------------------------------
  reg       p_we;
  reg [7:0] p_wa;
  reg [7:0] p_wd;

  always @* begin
    p_we = 1'b0;
    p_wa = ctr_addr;
    p_wd = `SMV_CTR_FULL;
    case (pstate)
      P_DEC: begin
        p_we = 1'b1;
        p_wd = dec8(mem[ctr_addr]); // (R3)
      end
      P_UPD: begin
        p_we = 1'b1;
        if (step[3]) begin
          p_wa = `SMV_S_BASE + {3'b000, kset, step[2:0]};
          p_wd = mix(buf_data[{1'b1, step[2:0]}],
                     buf_data[{1'b0, step[2:0]}], mem[c_addr], step);
        end else begin
          p_wa = c_addr;
          p_wd = mix(mem[c_addr], buf_data[{1'b0, step[2:0]}],
                     buf_data[{1'b1, step[2:0]}], step); // (R4)
        end
      end
      P_FIN: begin
        p_we = ~mismatch; // (R5)
      end
      P_PW: begin
        p_we = 1'b1;
        p_wa = pw_ctr; // (R10)
        p_wd = pw_match ? `SMV_CTR_FULL : dec8(mem[pw_ctr]); // (R13)
      end
      default: begin
        p_we = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // configuration memory
  // ----------------------------------------
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      for (n = 0; n < 256; n = n + 1)
        mem[n] <= `SMV_MEM_RESET; // (R15)
    end else if (p_we) begin
      mem[p_wa] <= p_wd;
    end else if (wb_mem_we) begin
      mem[cfg_index] <= WB_DAT_W[7:0]; // (R16)
    end
  end

  // ----------------------------------------
  // verify processing
  // ----------------------------------------
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      pstate   <= P_IDLE;
      step     <= 4'h0;
      wait_cnt <= 16'h0000;
      mismatch <= 1'b0;
      last_ok  <= 1'b0;
      unlocked <= 1'b0;
      fuse     <= `SMV_FUSE_RESET;
    end else begin
      case (pstate)
        P_IDLE: begin
          step     <= 4'h0;
          mismatch <= 1'b0;
          if (go) begin
            if (cmd == `SMV_CMD_VERIFY_AUTH)
              pstate <= P_DEC; // (R1)
            else if (cmd == `SMV_CMD_VERIFY_PW)
              pstate <= P_PW;
            else
              pstate <= P_FUSE;
          end
        end
        P_DEC: begin
          pstate <= P_CALC;
        end
        P_CALC: begin
          if (expect_ch != buf_data[{1'b1, step[2:0]}])
            mismatch <= 1'b1; // (R2)
          step <= step + 4'h1;
          if (step == 4'h7) begin
            step <= 4'h0;
            if (mismatch | (expect_ch != buf_data[{1'b1, step[2:0]}]))
              pstate <= P_FIN;
            else
              pstate <= P_UPD; // (R4)
          end
        end
        P_UPD: begin
          step <= step + 4'h1;
          if (step == 4'hF)
            pstate <= P_FIN;
        end
        P_FIN: begin
          last_ok  <= ~mismatch;
          wait_cnt <= NV_CYCLES;
          pstate   <= P_WAIT;
        end
        P_PW: begin
          last_ok <= pw_match;
          if (pw_match && p1 == `SMV_SECURE_CODE_IDX)
            unlocked <= 1'b1; // (R11)
          wait_cnt <= NV_CYCLES;
          pstate   <= P_WAIT;
        end
        P_FUSE: begin
          last_ok <= 1'b0;
          if (unlocked) begin
            if (p2 == `SMV_FUSE_ID_FAB) begin
              fuse[`SMV_FUSE_FAB_BIT] <= 1'b0;
              last_ok <= 1'b1;
            end else if (p2 == `SMV_FUSE_ID_CMA &&
                         !fuse[`SMV_FUSE_FAB_BIT]) begin
              fuse[`SMV_FUSE_CMA_BIT] <= 1'b0; // (R20)
              last_ok <= 1'b1;
            end else if (p2 == `SMV_FUSE_ID_PER &&
                         !fuse[`SMV_FUSE_CMA_BIT]) begin
              fuse[`SMV_FUSE_PER_BIT] <= 1'b0; // (R20)
              last_ok <= 1'b1;
            end
          end
          wait_cnt <= NV_CYCLES;
          pstate   <= P_WAIT;
        end
        P_WAIT: begin
          wait_cnt <= wait_cnt - 16'h0001;
          if (wait_cnt <= 16'h0001)
            pstate <= P_IDLE;
        end
        default: begin
          pstate <= P_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // serial byte engine
  // ----------------------------------------
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  // fuse state in low nibble, reserved bits zero
  wire [7:0] fuse_byte = {4'h0, fuse}; // (R18) (R21)

  function [7:0] tx_byte;
    input [7:0] a;
    begin
      if (cmd == `SMV_CMD_SYS_READ && p1 == `SMV_A1_FUSE)
        tx_byte = fuse_byte;
      else if (cmd == `SMV_CMD_SYS_READ && p1 == `SMV_A1_CONFIG)
        tx_byte = (unlocked || (a >= `SMV_OPEN_LO && a <= `SMV_OPEN_HI)) ?
                  mem[a] : fuse_byte; // (R14)
      else
        tx_byte = 8'hFF;
    end
  endfunction

  // key and password index checks on the index byte
  wire idx_ok = (cmd == `SMV_CMD_VERIFY_AUTH) ?
                (shift[7:5] == 3'b000 && shift[3:2] == 2'b00) : // (R6)
                (cmd == `SMV_CMD_VERIFY_PW) ?
                (shift[7:5] == 3'b000 && shift[3] == 1'b0) : // (R9)
                1'b1;
  wire accept = ~busy & ((byte_idx != 5'd1) | idx_ok); // (R22)
  wire last_rx = ((cmd == `SMV_CMD_VERIFY_AUTH) && byte_idx == 5'd19) ||
                 ((cmd == `SMV_CMD_VERIFY_PW) && byte_idx == 5'd6) ||
                 ((cmd == `SMV_CMD_SYS_WRITE) && p1 == `SMV_A1_FUSE &&
                  byte_idx == 5'd3);
  wire to_tx = ((cmd == `SMV_CMD_SYS_READ) ||
                (cmd == `SMV_CMD_READ_USER)) && byte_idx == 5'd3;

  always @(posedge CLK_SYS) begin
    if (RESET) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      active    <= 1'b0;
      tx_mode   <= 1'b0;
      nack_seen <= 1'b0;
      skip_fall <= 1'b0;
      bit_cnt   <= 4'h0;
      byte_idx  <= 5'd0;
      shift     <= 8'h00;
      tx_addr   <= 8'h00;
      cmd       <= 8'h00;
      p1        <= 8'h00;
      p2        <= 8'h00;
      nbyte     <= 8'h00;
      go        <= 1'b0;
      SDA_O     <= 1'b0;
      SDA_OE    <= 1'b0;
      for (m = 0; m < 16; m = m + 1)
        buf_data[m] <= 8'h00;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      go    <= 1'b0;
      if (start_c) begin
        active   <= 1'b1;
        tx_mode  <= 1'b0;
        bit_cnt  <= 4'h0;
        byte_idx <= 5'd0;
        SDA_OE   <= 1'b0;
        // clock fall closing the start is no bit
        skip_fall <= 1'b1;
      end else if (stop_c) begin
        active  <= 1'b0;
        tx_mode <= 1'b0;
        SDA_OE  <= 1'b0;
      end else if (active && scl_rise) begin
        if (bit_cnt < 4'h8 && !tx_mode)
          shift <= {shift[6:0], sda_s};
        else if (bit_cnt == 4'h8 && tx_mode)
          nack_seen <= sda_s;
      end else if (active && scl_fall && skip_fall) begin
        skip_fall <= 1'b0;
      end else if (active && scl_fall) begin
        if (bit_cnt < 4'h7) begin
          bit_cnt <= bit_cnt + 4'h1;
          if (tx_mode) begin
            shift  <= {shift[6:0], 1'b0};
            SDA_OE <= ~shift[6];
          end
        end else if (bit_cnt == 4'h7) begin
          bit_cnt <= 4'h8;
          if (tx_mode) begin
            SDA_OE <= 1'b0;
          end else if (accept) begin
            SDA_OE <= 1'b1;
            case (byte_idx)
              5'd0: cmd <= shift;
              5'd1: p1 <= shift;
              5'd2: p2 <= shift;
              5'd3: nbyte <= shift;
              default: buf_data[byte_idx[3:0] - 4'h4] <= shift; // (R1)
            endcase
          end else begin
            active <= 1'b0;
          end
        end else begin
          bit_cnt <= 4'h0;
          SDA_OE  <= 1'b0;
          if (tx_mode) begin
            if (nack_seen) begin
              active <= 1'b0;
            end else begin
              tx_addr <= tx_addr + 8'h01;
              shift   <= tx_byte(tx_addr + 8'h01);
              SDA_OE  <= ~|(tx_byte(tx_addr + 8'h01) & 8'h80);
            end
          end else begin
            if (byte_idx != 5'd31)
              byte_idx <= byte_idx + 5'd1;
            if (last_rx)
              go <= 1'b1; // (R1)
            if (to_tx) begin
              tx_mode   <= 1'b1;
              nack_seen <= 1'b0;
              tx_addr   <= p2;
              shift     <= tx_byte(p2);
              SDA_OE    <= ~|(tx_byte(p2) & 8'h80);
            end
          end
        end
      end
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      WB_ACK    <= 1'b0;
      WB_DAT_R  <= 32'h0000_0000;
      cfg_index <= 8'h00;
    end else begin
      WB_ACK <= wb_req;
      if (wb_req) begin
        if (WB_WE && WB_SEL[0] && WB_ADR == `SMV_REG_CFG_INDEX)
          cfg_index <= WB_DAT_W[7:0];
        case (WB_ADR)
          `SMV_REG_STATUS:
            WB_DAT_R <= {24'h00_0000, unlocked, busy, last_ok, 1'b0, fuse};
          `SMV_REG_CFG_INDEX:
            WB_DAT_R <= {24'h00_0000, cfg_index};
          `SMV_REG_CFG_DATA:
            WB_DAT_R <= {24'h00_0000, mem[cfg_index]};
          `SMV_REG_ZONE_RIGHTS:
            WB_DAT_R <= {mem[`SMV_ACCESS_BASE + 8'h06],
                         mem[`SMV_ACCESS_BASE + 8'h04],
                         mem[`SMV_ACCESS_BASE + 8'h02],
                         mem[`SMV_ACCESS_BASE]};
          default:
            WB_DAT_R <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* shared/smv_consts.vh */
`ifndef SMV_CONSTS_VH
`define SMV_CONSTS_VH

// ----------------------------------------
// command codes
// ----------------------------------------
`define SMV_CMD_READ_USER   8'hB2
`define SMV_CMD_SYS_WRITE   8'hB4
`define SMV_CMD_SYS_READ    8'hB6
`define SMV_CMD_VERIFY_AUTH 8'hB8
`define SMV_CMD_VERIFY_PW   8'hBA

// ----------------------------------------
// system command address 1 values
// ----------------------------------------
`define SMV_A1_CONFIG       8'h00
`define SMV_A1_FUSE         8'h01

// ----------------------------------------
// fuse ids and fuse byte layout
// ----------------------------------------
`define SMV_FUSE_ID_FAB     8'h06
`define SMV_FUSE_ID_CMA     8'h04
`define SMV_FUSE_ID_PER     8'h00
`define SMV_FUSE_FAB_BIT    0
`define SMV_FUSE_CMA_BIT    1
`define SMV_FUSE_PER_BIT    2
`define SMV_FUSE_SEC_BIT    3
`define SMV_FUSE_RESET      4'h7

// ----------------------------------------
// index, counter and fill values
// ----------------------------------------
`define SMV_SECURE_CODE_IDX 8'h07
`define SMV_CTR_FULL        8'hFF
`define SMV_MEM_RESET       8'hFF

// ----------------------------------------
// configuration memory map (byte addresses)
// ----------------------------------------
`define SMV_S_BASE          8'h00
`define SMV_ACCESS_BASE     8'h20
`define SMV_AUTH_BASE       8'h50
`define SMV_G_BASE          8'h90
`define SMV_PW_BASE         8'hB0
`define SMV_OPEN_LO         8'h20
`define SMV_OPEN_HI         8'h8F

// ----------------------------------------
// wishbone register byte offsets
// ----------------------------------------
`define SMV_REG_STATUS      8'h00
`define SMV_REG_CFG_INDEX   8'h04
`define SMV_REG_CFG_DATA    8'h08
`define SMV_REG_ZONE_RIGHTS 8'h0C

// ----------------------------------------
// timing
// ----------------------------------------
`define SMV_CLK_PERIOD_NS   10
`define SMV_T_NVWRITE_NS    10000

`endif

/* verification/smv_host.sv */
`timescale 1ns/100ps
`default_nettype none
module smv_host (
  // two-wire host side
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic start();
    #40 pull = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic bit_io(input logic b, output logic v);
    #20 pull = !b;
    #30 scl = 1'b1;
    #29 v = sda;
    #1 scl = 1'b0;
  endtask
  task automatic put(input logic [7:0] d, output logic a);
    logic v;
    for (int i = 7; i >= 0; i--) bit_io(d[i], v);
    bit_io(1'b1, v);
    a = !v;
  endtask
  task automatic get(output logic [7:0] d, input logic nak);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v);
      d[i] = v;
    end
    bit_io(nak, v);
  endtask
  task automatic stop();
    #10 pull = 1'b1;
    #30 scl = 1'b1;
    #40 pull = 1'b0;
    #40;
  endtask
endmodule
`default_nettype wire

/* verification/smv_props.sv */
`timescale 1ns/100ps
`default_nettype none
module smv_props #(
  parameter NV_WAIT = 1000
) (
  // system
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  // wishbone slave
  input wire logic        WB_CYC,
  input wire logic        WB_STB,
  input wire logic        WB_WE,
  input wire logic [7:0]  WB_ADR,
  input wire logic [3:0]  WB_SEL,
  input wire logic [31:0] WB_DAT_W,
  input wire logic [31:0] WB_DAT_R,
  input wire logic        WB_ACK,
  // two-wire link
  input wire logic        SCL,
  input wire logic        SDA_I,
  input wire logic        SDA_O,
  input wire logic        SDA_OE
);
  logic       st_q;
  logic       um_q;
  logic       seen_un;
  logic [3:0] fz_q;
  wire        take = WB_CYC && WB_STB && !WB_ACK;
  wire        st = WB_ACK && st_q;
  // ----------------------------------------
  // status and unmapped read tracking
  // ----------------------------------------
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      st_q <= 1'b0;
      um_q <= 1'b0;
      seen_un <= 1'b0;
      fz_q <= 4'h7;
    end else begin
      st_q <= take && !WB_WE && WB_ADR == 8'h00;
      um_q <= take && !WB_WE && WB_ADR > 8'h0C;
      if (st) begin
        seen_un <= seen_un | WB_DAT_R[7];
        fz_q <= WB_DAT_R[3:0];
      end
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  property p_ack_one; take |=> WB_ACK; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack late");
  property p_ack_pulse; WB_ACK |=> !WB_ACK; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
  property p_ack_cause; $rose(WB_ACK) |-> $past(take); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack no req");
  property p_dat_hold; !take |=> $stable(WB_DAT_R); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("rdata moved");
  property p_unmapped; WB_ACK && um_q |-> WB_DAT_R == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_fuse_resv; st |-> !WB_DAT_R[4] && !WB_DAT_R[3]; endproperty
  a_fuse_resv: assert property (p_fuse_resv) else $error("fuse resv");
  property p_fuse_order;
    st |-> (WB_DAT_R[1] || !WB_DAT_R[0]) && (WB_DAT_R[2] || !WB_DAT_R[1]);
  endproperty
  a_fuse_order: assert property (p_fuse_order) else $error("fuse order");
  property p_fuse_unlock; st && WB_DAT_R[2:0] != 3'h7 |-> WB_DAT_R[7];
  endproperty
  a_fuse_unlock: assert property (p_fuse_unlock) else $error("fuse lock");
  property p_unlock_keep; st && seen_un |-> WB_DAT_R[7]; endproperty
  a_unlock_keep: assert property (p_unlock_keep) else $error("relock");
  property p_fuse_mono; st |-> (WB_DAT_R[3:0] & ~fz_q) == 4'h0; endproperty
  a_fuse_mono: assert property (p_fuse_mono) else $error("fuse back");
  property p_sda_od; SDA_O == 1'b0; endproperty
  a_sda_od: assert property (p_sda_od) else $error("sda driven high");
  c_unlock: cover property (st && WB_DAT_R[7]);
  c_fuse_all: cover property (st && WB_DAT_R[3:0] == 4'h0);
  c_link_ack: cover property ($rose(SDA_OE));
endmodule
`default_nettype wire

/* verification/smv_verify_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
module smv_verify_top_test;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dw = 32'h0000_0000;
  logic [31:0] dr;
  logic        ack, scl, pull, sda_o, sda_oe;
  wire         sda = !(sda_oe || pull);
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc_cnt = 0;
  logic [7:0]  pi[3] = '{8'h17, 8'h07, 8'h07};
  logic [7:0]  pv[3] = '{8'h00, 8'h00, 8'hFF};
  logic [7:0]  pc[3] = '{8'hEC, 8'hE8, 8'hE8};
  logic [7:0]  pe[3] = '{8'hFE, 8'hFE, 8'hFF};
  logic [15:0] bad[5] = '{16'hBA08, 16'hBA18, 16'hB804, 16'hB814, 16'hB820};
  logic [7:0]  fid[4] = '{8'h04, 8'h06, 8'h04, 8'h00};
  logic [3:0]  fex[4] = '{4'h7, 4'h6, 4'h4, 4'h0};
  logic [7:0]  ki[3] = '{8'h00, 8'h11, 8'h02};
  logic [7:0]  ka[3] = '{8'h50, 8'h60, 8'h70};
  always #5 clk_sys = ~clk_sys;
  smv_verify_top #(.NV_WAIT(200)) dut (
    .CLK_SYS(clk_sys), .RESET(reset), .WB_CYC(cyc), .WB_STB(stb),
    .WB_WE(we), .WB_ADR(adr), .WB_SEL(4'h1), .WB_DAT_W(dw),
    .WB_DAT_R(dr), .WB_ACK(ack), .SCL(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe));
  smv_host host (.scl(scl), .pull(pull), .sda(sda));
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 80000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk_wb(input logic [31:0] g, e, input string m);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_link(input logic [7:0] g, e, input string m);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) chk_wb(0, 1, "wb timeout");
    r = dr;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic cfg_rd(input logic [7:0] i, output logic [31:0] r);
    wb(1'b1, 8'h04, {24'h0, i}, r);
    wb(1'b0, 8'h08, 32'h0000_0000, r);
  endtask
  task automatic frame(input logic [7:0] q[$], output int n);
    logic a;
    n = 0;
    @(negedge clk_sys);
    host.start();
    foreach (q[i]) begin
      host.put(q[i], a);
      if (!a) break;
      n++;
    end
    host.stop();
  endtask
  task automatic link_rd(input logic [7:0] c, a1, a2,
                         output logic [7:0] d, output logic f);
    logic a;
    int k;
    k = 0;
    do begin
      @(negedge clk_sys);
      host.start();
      host.put(c, a);
      if (k == 0) f = a;
      if (!a) host.stop();
      k++;
    end while (!a && k < 60);
    host.put(a1, a);
    host.put(a2, a);
    host.put(8'h01, a);
    host.get(d, 1'b1);
    host.stop();
  endtask
  initial begin
    logic [31:0] r;
    logic [7:0]  d;
    logic [7:0]  q[$];
    logic        f;
    int          n;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (8) @(posedge clk_sys);
    wb(1'b0, 8'h00, 0, r); chk_wb(r, 32'h0000_0007, "status");
    wb(1'b0, 8'h0C, 0, r); chk_wb(r, 32'hFFFF_FFFF, "rights");
    wb(1'b0, 8'h40, 0, r); chk_wb(r, 32'h0000_0000, "unmapped");
    wb(1'b1, 8'h08, 32'h0000_0000, r);
    wb(1'b0, 8'h08, 0, r); chk_wb(r, 32'h0000_00FF, "locked");
    link_rd(8'hB6, 8'h00, 8'hE9, d, f);
    chk_link(d, 8'h07, "hidden code");
    frame('{8'hB0, 8'h00, 8'h00, 8'h01, 8'h5A}, n);
    chk_link(n[7:0], 8'h05, "user write");
    $display("test reset done");
    foreach (bad[i]) begin
      frame('{bad[i][15:8], bad[i][7:0], 8'h00, 8'h03}, n);
      chk_link(n[7:0], 8'h01, "bad index");
    end
    $display("test index done");
    for (int i = 0; i < 3; i++) begin
      frame('{8'hBA, pi[i], 8'h00, 8'h03, pv[i], pv[i], pv[i]}, n);
      chk_link(n[7:0], 8'h07, "pw frame");
      link_rd(8'hB6, 8'h01, 8'h00, d, f);
      chk_link({7'h0, f}, 8'h00, "busy ack");
      cfg_rd(pc[i], r); chk_wb(r, {24'h0, pe[i]}, "pw ctr");
      wb(1'b0, 8'h00, 0, r); chk_wb(r[7], i == 2, "unlock");
    end
    link_rd(8'hB6, 8'h00, 8'hE9, d, f);
    chk_link(d, 8'hFF, "code");
    wb(1'b1, 8'h04, 32'h0000_0020, r);
    wb(1'b1, 8'h08, 32'h0000_0055, r);
    wb(1'b0, 8'h0C, 0, r); chk_wb(r, 32'hFFFF_FF55, "rights");
    $display("test password done");
    for (int i = 0; i < 3; i++) begin
      q = '{8'hB8, ki[i], 8'h00, 8'h10};
      for (int j = 0; j < 8; j++) q.push_back(i == 2 ? 8'h01 : 8'(j + 1));
      for (int j = 0; j < 8; j++)
        q.push_back(i == 2 ? 8'hFD ^ 8'(j - 1) : 8'h5A);
      frame(q, n);
      chk_link(n[7:0], 8'h14, "auth frame");
      link_rd(8'hB2, 8'h00, 8'h00, d, f);
      chk_link({7'h0, f}, 8'h00, "busy ack");
      chk_link(d, 8'hFF, "user read");
      cfg_rd(ka[i], r);
      chk_wb(r, i == 2 ? 32'h0000_00FF : 32'h0000_00FE, "ctr");
      cfg_rd(ka[i] + 8'h01, r);
      chk_wb(r, i == 2 ? 32'h0000_00FC : 32'h0000_00FF, "crypt");
    end
    $display("test auth done");
    for (int i = 0; i < 4; i++) begin
      frame('{8'hB4, 8'h01, fid[i], 8'h00}, n);
      link_rd(8'hB6, 8'h01, 8'h00, d, f);
      chk_link(d, {4'h0, fex[i]}, "fuse byte");
      wb(1'b0, 8'h00, 0, r); chk_wb(r[3:0], fex[i], "fuse stat");
    end
    $display("test fuse done");
    finish_test();
  end
endmodule
bind smv_verify_top smv_props #(.NV_WAIT(NV_WAIT)) u_props (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .WB_CYC(WB_CYC), .WB_STB(WB_STB),
  .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_W(WB_DAT_W),
  .WB_DAT_R(WB_DAT_R), .WB_ACK(WB_ACK), .SCL(SCL), .SDA_I(SDA_I),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE));
`default_nettype wire
